/* verification/detector_pin_model.sv */
// model of the reset pin, supply detectors, test reset and watchdog oscillator
// assumes the bench calls its tasks right after a rising clock edge
`timescale 1ns/1ps
module detector_pin_model #(
    parameter int OSC_HALF = 2
) (
    input wire logic clk_i,
    output logic supply_low_o,
    output logic reset_pin_n_o,
    output logic brownout_o,
    output logic test_reset_o,
    output logic wdt_osc_o
);
    int osc_cnt = 0;

    // power comes up low; pin rests at its pull-up level
    initial begin
        supply_low_o = 1'b1;
        reset_pin_n_o = 1'b1;
        brownout_o = 1'b0;
        test_reset_o = 1'b0;
        wdt_osc_o = 1'b0;
    end

    // own oscillator, sped up so a period fits the run
    always @(posedge clk_i) begin
        if (osc_cnt == OSC_HALF - 1) begin
            osc_cnt <= 0;
            wdt_osc_o <= ~wdt_osc_o;
        end else begin
            osc_cnt <= osc_cnt + 1;
        end
    end

    // 0 supply, 1 pin (active low), 2 brown-out, 3 test reset
    task automatic set_line(input int which, input logic on);
        case (which)
            0: supply_low_o <= on;
            1: reset_pin_n_o <= ~on;
            2: brownout_o <= on;
            default: test_reset_o <= on;
        endcase
    endtask

    task automatic hold(input int which, input int n);
        set_line(which, 1'b1);
        repeat (n) @(posedge clk_i);
        set_line(which, 1'b0);
    endtask
endmodule

/* verification/reset_wdt_checker_sva.sv */
// assertions on the reset controller top ports
// assumes a bind to the top module, static fuses and ce_i held high
`timescale 1ns/1ps
`include "reset_ctl_regs.svh"
module reset_wdt_checker #(
    parameter int unsigned DLY_SHORT_CYCLES = 20,
    parameter int unsigned DLY_LONG_CYCLES = 50
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic supply_low_i,
    input wire logic reset_pin_n_i,
    input wire logic brownout_detector_i,
    input wire logic test_reset_i,
    input wire logic converter_enable_i,
    input wire logic brownout_enable_setting_i,
    input wire logic chip_reset_o,
    input wire logic port_force_o,
    input wire logic restart_vector_o,
    input wire logic voltage_ref_enable_o
);
    localparam int PIN_LIM = `EXT_MIN_CYCLES + 6;
    localparam int BOD_LIM = `BOD_MIN_CYCLES + 6;
    int pin_lo_q;
    int bod_hi_q;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // run lengths of the filtered sources; the margin covers sync and register
    always_ff @(posedge clk_i) begin
        pin_lo_q <= reset_pin_n_i ? 0 : pin_lo_q + 1;
    end
    always_ff @(posedge clk_i) begin
        bod_hi_q <= (brownout_detector_i && brownout_enable_setting_i) ? bod_hi_q + 1 : 0;
    end

    property p_force;
        (supply_low_i || !reset_pin_n_i || test_reset_i ||
         (brownout_detector_i && brownout_enable_setting_i)) |-> port_force_o;
    endproperty
    a_force: assert property (p_force) else $error("port force missing");
    property p_supply;
        supply_low_i |-> ##[1:3] chip_reset_o;
    endproperty
    a_supply: assert property (p_supply) else $error("supply low no reset");
    property p_test;
        test_reset_i [*4] |-> chip_reset_o;
    endproperty
    a_test: assert property (p_test) else $error("test reset not held");
    property p_pin;
        pin_lo_q >= PIN_LIM |-> chip_reset_o;
    endproperty
    a_pin: assert property (p_pin) else $error("long pin low no reset");
    property p_bod;
        bod_hi_q >= BOD_LIM |-> chip_reset_o;
    endproperty
    a_bod: assert property (p_bod) else $error("brown-out no reset");
    property p_vec;
        $fell(chip_reset_o) |-> restart_vector_o;
    endproperty
    a_vec: assert property (p_vec) else $error("no vector at release");
    property p_vec_one;
        restart_vector_o |=> !restart_vector_o && !chip_reset_o;
    endproperty
    a_vec_one: assert property (p_vec_one) else $error("vector pulse too long");
    property p_rel;
        $fell(chip_reset_o) |-> !$past(test_reset_i, 2) && !$past(supply_low_i, 2);
    endproperty
    a_rel: assert property (p_rel) else $error("release with source active");
    property p_ref;
        (converter_enable_i || brownout_enable_setting_i) && !rst_i |=> voltage_ref_enable_o;
    endproperty
    a_ref: assert property (p_ref) else $error("reference not enabled");

    c_vec: cover property (restart_vector_o);
    c_pin: cover property (pin_lo_q == PIN_LIM);
    c_bod: cover property (bod_hi_q == BOD_LIM);
endmodule

/* verification/system_reset_and_watchdog_test.sv */
// self-checking bench: bus, reset sources, stretch delay, watchdog
// assumes the detector model drives the source lines and ce_i stays high
`timescale 1ns/1ps
`include "reset_ctl_regs.svh"
module system_reset_and_watchdog_test;
    localparam int SHORT = 20;
    localparam int LONG = 50;
    localparam int WDT_CYC = 16384 * 4;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic restart = 1'b0;
    logic conv = 1'b0;
    logic [3:0] fuse = 4'h0;
    logic bod_fuse = 1'b0;
    logic [31:0] rdat;
    logic ack, chip_rst, force_pins, vec, ref_en;
    logic supply_low, pin_n, brownout_detector, test_rst, osc;
    int n_fail = 0;
    int checked = 0;
    int seed = 2;

    always #5 clk_i = ~clk_i;

    system_reset_and_watchdog #(.DLY_SHORT_CYCLES(SHORT), .DLY_LONG_CYCLES(LONG))
        system_reset_and_watchdog_inst (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .supply_low_i(supply_low),
        .reset_pin_n_i(pin_n), .brownout_detector_i(brownout_detector), .test_reset_i(test_rst),
        .wdt_osc_i(osc), .watchdog_restart_i(restart), .converter_enable_i(conv),
        .clock_select_settings_i(fuse), .brownout_enable_setting_i(bod_fuse),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .chip_reset_o(chip_rst),
        .port_force_o(force_pins), .restart_vector_o(vec), .voltage_ref_enable_o(ref_en));

    detector_pin_model #(.OSC_HALF(2)) detector_pin_model_inst (
        .clk_i(clk_i), .supply_low_o(supply_low), .reset_pin_n_o(pin_n),
        .brownout_o(brownout_detector), .test_reset_o(test_rst), .wdt_osc_o(osc));

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // classic cycle held until ack is seen at a rising edge, then one idle cycle
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic expect_reg(input string what, input logic [7:0] a, input logic [31:0] mask,
                              input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        check(what, q & mask, exp);
    endtask

    // read the flags, then clear them with a write of zero
    task automatic flags_are(input logic [31:0] exp);
        expect_reg("reset flags", `REG_RESET_FLAGS, 32'h1f, exp);
        wr(`REG_RESET_FLAGS, 32'h0);
    endtask

    task automatic until_rst(input logic lvl, input int lim, output int n);
        n = 0;
        while (chip_rst !== lvl && n < lim) begin
            @(posedge clk_i);
            n++;
        end
        check("reset level", {31'h0, chip_rst}, {31'h0, lvl});
    endtask

    task automatic settle_rst(input string what, input logic exp);
        repeat (6) @(posedge clk_i);
        check(what, {31'h0, chip_rst}, {31'h0, exp});
        check("force idle", {31'h0, force_pins}, 32'h0);
    endtask

    // fuses change only while the whole device is held in reset
    task automatic power_up(input logic [3:0] code, input logic bf, output int n);
        rst_i <= 1'b1;
        fuse <= code;
        bod_fuse <= bf;
        detector_pin_model_inst.set_line(0, 1'b1);
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        detector_pin_model_inst.set_line(0, 1'b0);
        until_rst(1'b0, 400, n);
    endtask

    task automatic ref_sweep();
        for (int i = 0; i < 4; i++) begin
            wr(`REG_REF_CTRL, {31'h0, i[0]});
            conv <= i[1];
            repeat (2) @(posedge clk_i);
            expect_reg("ref", `REG_REF_CTRL, 32'h11, {27'h0, bod_fuse | i[0] | i[1], 3'h0, i[0]});
        end
    endtask

    function automatic int dly(input logic [1:0] code);
        return code[1] ? LONG : (code[0] ? SHORT : 1);
    endfunction

    initial begin
        int n;
        int len;
        for (int c = 0; c < 3; c++) begin
            power_up(c[3:0], 1'b0, n);
            check("stretch", 32'(n >= dly(c[1:0]) + 2 && n <= dly(c[1:0]) + 8), 32'h1);
        end
        expect_reg("unmapped", 8'h40, 32'hffffffff, 32'h0);
        wr(8'h40, 32'h0);
        flags_are(32'h01);
        expect_reg("state", `REG_REF_CTRL, 32'h700, 32'h400);
        detector_pin_model_inst.hold(1, 200);
        check("pin reset", {31'h0, chip_rst}, 32'h1);
        until_rst(1'b0, 200, n);
        check("pin release", 32'(n >= LONG + 1 && n <= LONG + 8), 32'h1);
        flags_are(32'h02);
        // random short pulses, the last just under the minimum width
        for (int i = 0; i < 4; i++) begin
            len = (i == 3) ? 149 : 5 + {$random(seed)} % 140;
            detector_pin_model_inst.hold(1, len);
            settle_rst("short pin", 1'b0);
        end
        detector_pin_model_inst.hold(3, 100);
        check("test hold", {31'h0, chip_rst}, 32'h1);
        until_rst(1'b0, 200, n);
        flags_are(32'h10);
        detector_pin_model_inst.hold(2, 300);
        settle_rst("bod fused off", 1'b0);
        ref_sweep();
        power_up(4'h0, 1'b1, n);
        flags_are(32'h01);
        detector_pin_model_inst.hold(2, 150);
        settle_rst("bod short", 1'b0);
        detector_pin_model_inst.hold(2, 300);
        check("bod reset", {31'h0, chip_rst}, 32'h1);
        until_rst(1'b0, 50, n);
        flags_are(32'h04);
        ref_sweep();
        for (int p = 0; p < 8; p++) begin
            wr(`REG_WDT_CTRL, 32'h8 | p);
            expect_reg("prescale", `REG_WDT_CTRL, 32'h1f, 32'h8 | p);
        end
        wr(`REG_WDT_CTRL, 32'h0);
        expect_reg("plain off", `REG_WDT_CTRL, 32'h8, 32'h8);
        wr(`REG_WDT_CTRL, 32'h18);
        repeat (8) @(posedge clk_i);
        expect_reg("toe clear", `REG_WDT_CTRL, 32'h18, 32'h8);
        wr(`REG_WDT_CTRL, 32'h0);
        expect_reg("late off", `REG_WDT_CTRL, 32'h8, 32'h8);
        wr(`REG_WDT_CTRL, 32'h18);
        wr(`REG_WDT_CTRL, 32'h0);
        expect_reg("guarded off", `REG_WDT_CTRL, 32'hf, 32'h0);
        // a restart mid-period must push expiry a full period out
        wr(`REG_WDT_CTRL, 32'h8);
        repeat (20000) @(posedge clk_i);
        restart <= 1'b1;
        @(posedge clk_i);
        restart <= 1'b0;
        until_rst(1'b1, WDT_CYC + 100, n);
        check("expiry", 32'(n >= WDT_CYC - 16 && n <= WDT_CYC + 16), 32'h1);
        until_rst(1'b0, 50, n);
        flags_are(32'h08);
        expect_reg("wdt cleared", `REG_WDT_CTRL, 32'h1f, 32'h0);
        complete_run();
    end

    // the run needs about 90k cycles; a hang is cut short below 100k
    initial begin
        #980000;
        n_fail++;
        complete_run();
    end
endmodule

bind system_reset_and_watchdog reset_wdt_checker #(
    .DLY_SHORT_CYCLES(DLY_SHORT_CYCLES), .DLY_LONG_CYCLES(DLY_LONG_CYCLES)
) reset_wdt_checker_inst (
    .clk_i(clk_i), .rst_i(rst_i), .supply_low_i(supply_low_i),
    .reset_pin_n_i(reset_pin_n_i), .brownout_detector_i(brownout_detector_i),
    .test_reset_i(test_reset_i), .converter_enable_i(converter_enable_i),
    .brownout_enable_setting_i(brownout_enable_setting_i), .chip_reset_o(chip_reset_o),
    .port_force_o(port_force_o), .restart_vector_o(restart_vector_o),
    .voltage_ref_enable_o(voltage_ref_enable_o));

/* verilog/reset_ctl_pkg.sv */
// types shared by the reset controller files
// assumes nothing beyond a systemverilog compiler
package reset_ctl_pkg;
    typedef enum logic [2:0] {
        ST_HOLD = 3'b001,
        ST_DELAY = 3'b010,
        ST_RUN = 3'b100
    } seq_state_t;
endpackage

/* verilog/reset_ctl_regs.svh */
// offsets, field positions, reset values and timing counts of the reset controller
// assumes a 100 MHz system clock and a 32-bit classic wishbone register port
`ifndef RESET_CTL_REGS_SVH
`define RESET_CTL_REGS_SVH

// register byte offsets
`define REG_RESET_FLAGS 8'h00
`define REG_WDT_CTRL 8'h04
`define REG_REF_CTRL 8'h08

// reset flag field positions
`define FLAG_POR 0
`define FLAG_EXT 1
`define FLAG_BOR 2
`define FLAG_WDT 3
`define FLAG_TEST 4
`define FLAG_W 5

// watchdog control field positions
`define WDT_PRESCALE_LSB 0
`define WDT_PRESCALE_MSB 2
`define WDT_ENABLE_BIT 3
`define WDT_TURNOFF_BIT 4

// reference control field positions
`define REF_BANDGAP_BIT 0
`define REF_ENABLE_BIT 4
`define REF_STATE_LSB 8
`define REF_STATE_MSB 10

// reset values
`define FLAGS_RESET 5'h00
`define WDT_CTRL_RESET 5'h00
`define REF_CTRL_RESET 1'h0

// timing, times in their own unit, counts derived
`define CLK_PERIOD_NS 10
`define EXT_MIN_PULSE_NS 1500
`define EXT_MIN_CYCLES ((`EXT_MIN_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BOD_MIN_NS 2000
`define BOD_MIN_CYCLES ((`BOD_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DLY_SHORT_US 4100
`define DLY_LONG_US 65000
`define DLY_SHORT_CYCLES ((`DLY_SHORT_US * 1000) / `CLK_PERIOD_NS)
`define DLY_LONG_CYCLES ((`DLY_LONG_US * 1000) / `CLK_PERIOD_NS)
`define DLY_NONE_CYCLES 1
`define TOE_WINDOW_CYCLES 4
`define WDT_BASE_CYCLES 22'h004000

`endif

/* verilog/system_reset_and_watchdog.sv */
// system reset controller: five sources, stretch delay, watchdog, reference enable
// assumes fuse settings are static while powered, and a wishbone master on clk_i
`timescale 1ns/1ps
`include "reset_ctl_regs.svh"

// Behaviour
// - reset clears registers, core restarts at vector
// - any source forces port pins immediately; the watchdog does so only through chip_reset_o, one cycle later
// - port forcing needs no running clock
// - all released, delay counter stretches reset
// - delay length chosen by fuse settings
// - OR exactly five reset request inputs
// - test reset register one holds reset
// - supply good starts delay before release
// - supply low reasserts reset without delay
// - long pin low resets, short may not
// - pin high starts delay, then release
// - brown-out enabled only by fuse setting
// - brown-out resets at once, delayed release
// - short brown-out indications are ignored
// - watchdog expiry gives one-cycle reset pulse
// - delay starts on watchdog pulse falling edge
// - watchdog counts its own oscillator
// - restart instruction clears watchdog counter
// - disable or chip reset clears counter
// - eight selectable watchdog periods
// - expiry while enabled resets the device
// - watchdog disabled only by protected sequence
// - reference on for brown-out, bandgap, converter
// - prescale codes give 16K to 2048K cycles
// - turn-off enable self-clears after four cycles
// - per-source flags, supply-on clears others
module system_reset_and_watchdog #(
    parameter int unsigned DLY_SHORT_CYCLES = `DLY_SHORT_CYCLES,
    parameter int unsigned DLY_LONG_CYCLES = `DLY_LONG_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic supply_low_i,
    input wire logic reset_pin_n_i,
    input wire logic brownout_detector_i,
    input wire logic test_reset_i,
    input wire logic wdt_osc_i,
    input wire logic watchdog_restart_i,
    input wire logic converter_enable_i,
    input wire logic [3:0] clock_select_settings_i,
    input wire logic brownout_enable_setting_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic chip_reset_o,
    output logic port_force_o,
    output logic restart_vector_o,
    output logic voltage_ref_enable_o
);
    // synchroniser order: osc, test, brown-out, pin low, supply low
    logic [4:0] meta_q;
    logic [4:0] sync_q;
    logic osc_last_q;
    logic osc_tick;
    logic supply_low_s;
    logic pin_low_s;
    logic bod_s;
    logic test_s;
    logic [15:0] pin_cnt_q;
    logic [15:0] bod_cnt_q;
    logic pin_low_f;
    logic bod_f;
    logic wdt_fire;
    logic request;
    reset_ctl_pkg::seq_state_t state_q;
    reset_ctl_pkg::seq_state_t state_d;
    logic [31:0] delay_q;
    logic chip_clear;
    logic [`FLAG_W-1:0] flags_q;
    logic wde_q;
    logic toe_q;
    logic [2:0] toe_cnt_q;
    logic [2:0] wdp_q;
    logic bandgap_q;
    logic bus_req;
    logic bus_wr;
    logic wr_flags;
    logic wr_wdt;
    logic wr_ref;

    // stretch length selected by the fuse code, never by software
    function automatic logic [31:0] delay_cycles(input logic [3:0] sel);
        case (sel[1:0])
            2'b00: delay_cycles = 32'(`DLY_NONE_CYCLES);
            2'b01: delay_cycles = 32'(DLY_SHORT_CYCLES);
            default: delay_cycles = 32'(DLY_LONG_CYCLES);
        endcase
    endfunction

    // filter counter: saturates at the limit while raw is active, drops at once otherwise
    function automatic logic [15:0] filt_next(input logic raw, input logic [15:0] cnt,
                                              input logic [15:0] lim);
        if (!raw) begin
            filt_next = 16'h0000;
        end else if (cnt == lim) begin
            filt_next = cnt;
        end else begin
            filt_next = cnt + 16'h0001;
        end
    endfunction

    // two-stage synchroniser on every pin-level input;
    // supply reads low until sampled, so reset never ends before the pins are seen
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_q <= 5'h10;
            sync_q <= 5'h10;
        end else if (ce_i) begin
            meta_q <= {supply_low_i, ~reset_pin_n_i, brownout_detector_i, test_reset_i, wdt_osc_i};
            sync_q <= meta_q;
        end
    end

    // edge detector behind the second stage, idle low like the oscillator
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            osc_last_q <= 1'b0;
        end else if (ce_i) begin
            osc_last_q <= sync_q[0];
        end
    end

    assign osc_tick = sync_q[0] & ~osc_last_q;
    assign test_s = sync_q[1];
    assign bod_s = sync_q[2] & brownout_enable_setting_i;
    assign pin_low_s = sync_q[3];
    assign supply_low_s = sync_q[4];

    // minimum width filter on the pin; shorter lows are dropped
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_cnt_q <= 16'h0000;
        end else if (ce_i) begin
            pin_cnt_q <= filt_next(pin_low_s, pin_cnt_q, 16'(`EXT_MIN_CYCLES));
        end
    end

    // minimum width filter on the brown-out indication
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bod_cnt_q <= 16'h0000;
        end else if (ce_i) begin
            bod_cnt_q <= filt_next(bod_s, bod_cnt_q, 16'(`BOD_MIN_CYCLES));
        end
    end

    assign pin_low_f = (pin_cnt_q == 16'(`EXT_MIN_CYCLES));
    assign bod_f = (bod_cnt_q == 16'(`BOD_MIN_CYCLES));

    // combined request of the five sources
    assign request = supply_low_s | pin_low_f | wdt_fire | bod_f | test_s;

    // port forcing takes the raw source inputs past every flop so it works with the clock stopped;
    // this is the one output that is not registered, by necessity
    assign port_force_o = supply_low_i | ~reset_pin_n_i | test_reset_i | chip_reset_o |
        (brownout_detector_i & brownout_enable_setting_i);

    // sequencer: hold while any source is active, then count the stretch
    always_comb begin
        state_d = state_q;
        case (state_q)
            reset_ctl_pkg::ST_HOLD: begin
                if (!request) begin
                    state_d = reset_ctl_pkg::ST_DELAY;
                end
            end
            reset_ctl_pkg::ST_DELAY: begin
                if (request) begin
                    state_d = reset_ctl_pkg::ST_HOLD;
                end else if (delay_q <= 32'h00000001) begin
                    state_d = reset_ctl_pkg::ST_RUN;
                end
            end
            reset_ctl_pkg::ST_RUN: begin
                if (request) begin
                    state_d = reset_ctl_pkg::ST_HOLD;
                end
            end
            default: state_d = reset_ctl_pkg::ST_HOLD;
        endcase
    end

    // sequencer state
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= reset_ctl_pkg::ST_HOLD;
        end else if (ce_i) begin
            state_q <= state_d;
        end
    end

    // stretch counter, reloaded from the fuse code outside the delay state
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            delay_q <= 32'h00000000;
        end else if (ce_i) begin
            if (state_q != reset_ctl_pkg::ST_DELAY) begin
                delay_q <= delay_cycles(clock_select_settings_i);
            end else begin
                delay_q <= delay_q - 32'h00000001;
            end
        end
    end

    // release only on a clock edge, never mid-cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            chip_reset_o <= 1'b1;
        end else if (ce_i) begin
            chip_reset_o <= (state_d != reset_ctl_pkg::ST_RUN);
        end
    end

    // one-cycle start pulse at the release edge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            restart_vector_o <= 1'b0;
        end else if (ce_i) begin
            restart_vector_o <= (state_q == reset_ctl_pkg::ST_DELAY) &&
                (state_d == reset_ctl_pkg::ST_RUN);
        end
    end

    assign chip_clear = rst_i | chip_reset_o;

    watchdog_counter u_wdt (
        .clk_i(clk_i),
        .clear_i(chip_clear),
        .ce_i(ce_i),
        .osc_tick_i(osc_tick),
        .enable_i(wde_q),
        .restart_i(watchdog_restart_i),
        .prescale_i(wdp_q),
        .expire_o(wdt_fire)
    );

    // wishbone decode; a write lands on the edge that sees ack high
    assign bus_req = wb_cyc_i & wb_stb_i;
    assign bus_wr = bus_req & wb_we_i & wb_ack_o & wb_sel_i[0];
    assign wr_flags = bus_wr && (wb_adr_i == `REG_RESET_FLAGS);
    assign wr_wdt = bus_wr && (wb_adr_i == `REG_WDT_CTRL);
    assign wr_ref = bus_wr && (wb_adr_i == `REG_REF_CTRL);

    // reset cause flags survive chip reset; supply-on wipes the rest
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flags_q <= `FLAGS_RESET;
        end else if (ce_i) begin
            if (supply_low_s) begin
                flags_q <= 5'h01 << `FLAG_POR;
            end else begin
                // a set in the same cycle as a software clear wins
                flags_q <= (flags_q & ~({5{wr_flags}} & ~wb_dat_i[`FLAG_W-1:0])) |
                    {test_s, wdt_fire, bod_f, pin_low_f, 1'b0};
            end
        end
    end

    // watchdog control with the protected turn-off sequence
    always_ff @(posedge clk_i) begin
        if (chip_clear) begin
            wde_q <= 1'b0;
            toe_q <= 1'b0;
            toe_cnt_q <= 3'h0;
            wdp_q <= 3'h0;
        end else if (ce_i) begin
            if (wr_wdt) begin
                wdp_q <= wb_dat_i[`WDT_PRESCALE_MSB:`WDT_PRESCALE_LSB];
                // clearing enable only counts while turn-off enable is up
                if (wb_dat_i[`WDT_ENABLE_BIT] || toe_q) begin
                    wde_q <= wb_dat_i[`WDT_ENABLE_BIT];
                end
            end
            if (wr_wdt && wb_dat_i[`WDT_TURNOFF_BIT]) begin
                toe_q <= 1'b1;
                toe_cnt_q <= 3'(`TOE_WINDOW_CYCLES);
            end else if (toe_cnt_q == 3'h1) begin
                toe_q <= 1'b0;
                toe_cnt_q <= 3'h0;
            end else if (toe_cnt_q != 3'h0) begin
                toe_cnt_q <= toe_cnt_q - 3'h1;
            end
        end
    end

    // comparator bandgap select and the reference enable
    always_ff @(posedge clk_i) begin
        if (chip_clear) begin
            bandgap_q <= `REF_CTRL_RESET;
        end else if (ce_i && wr_ref) begin
            bandgap_q <= wb_dat_i[`REF_BANDGAP_BIT];
        end
    end

    // reference on while any of its three users needs it, one cycle late
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            voltage_ref_enable_o <= 1'b0;
        end else if (ce_i) begin
            voltage_ref_enable_o <= brownout_enable_setting_i | bandgap_q |
                converter_enable_i;
        end
    end

    // ack one cycle after the request, dropped the cycle after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else if (ce_i) begin
            wb_ack_o <= bus_req & ~wb_ack_o;
        end
    end

    // read data launched with ack; unmapped offsets read zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h00000000;
        end else if (ce_i) begin
            if (bus_req && !wb_ack_o) begin
                wb_dat_o <= 32'h00000000;
                case (wb_adr_i)
                    `REG_RESET_FLAGS: wb_dat_o[`FLAG_W-1:0] <= flags_q;
                    `REG_WDT_CTRL: wb_dat_o[4:0] <= {toe_q, wde_q, wdp_q};
                    `REG_REF_CTRL: begin
                        wb_dat_o[`REF_BANDGAP_BIT] <= bandgap_q;
                        wb_dat_o[`REF_ENABLE_BIT] <= voltage_ref_enable_o;
                        wb_dat_o[`REF_STATE_MSB:`REF_STATE_LSB] <= state_q;
                    end
                    default: wb_dat_o <= 32'h00000000;
                endcase
            end
        end
    end
endmodule

/* verilog/watchdog_counter.sv */
// watchdog counter stepped by ticks of its own oscillator
// assumes osc_tick_i is already synchronised into the system clock domain
`timescale 1ns/1ps
`include "reset_ctl_regs.svh"

module watchdog_counter (
    input wire logic clk_i,
    input wire logic clear_i,
    input wire logic ce_i,
    input wire logic osc_tick_i,
    input wire logic enable_i,
    input wire logic restart_i,
    input wire logic [2:0] prescale_i,
    output logic expire_o
);
    logic [21:0] count_q;

    // period in oscillator cycles, doubling for each prescale step
    function automatic logic [21:0] period(input logic [2:0] sel);
        period = `WDT_BASE_CYCLES << sel;
    endfunction

    // count oscillator ticks; cleared by restart, disable or chip reset
    always_ff @(posedge clk_i) begin
        if (clear_i) begin
            count_q <= 22'h000000;
        end else if (ce_i) begin
            if (restart_i || !enable_i) begin
                count_q <= 22'h000000;
            end else if (osc_tick_i) begin
                if (count_q == period(prescale_i) - 22'h000001) begin
                    count_q <= 22'h000000;
                end else begin
                    count_q <= count_q + 22'h000001;
                end
            end
        end
    end

    // expiry is one system clock wide, the tick itself lasts one cycle
    always_ff @(posedge clk_i) begin
        if (clear_i) begin
            expire_o <= 1'b0;
        end else if (ce_i) begin
            expire_o <= enable_i && !restart_i && osc_tick_i &&
                (count_q == period(prescale_i) - 22'h000001);
        end
    end
endmodule
